// *** bench/serial_program_command_decoder_tb.sv ***
/* serial_program_command_decoder_tb: self-checking bench of the decoder.
   Assumes a memory side that answers reads half a cycle after the request. */
`timescale 1ns/1ps
`default_nettype none
module serial_program_command_decoder_tb;
	import spcd_pkg::*;
	localparam logic [7:0] SIGS [4] = '{8'h5c, 8'ha3, 8'h3e, 8'hff};
	localparam logic [7:0] CAL = 8'h7b;
	localparam logic [7:0] SUBS [4] = '{SUB_LOCK, SUB_FUSE_LO, SUB_FUSE_HI, SUB_FUSE_EXT};
	localparam logic [7:0] ROP [3] = '{OP_READ_LO, OP_READ_HI, OP_READ_EE};
	localparam spcd_memop_e MOP [3] = '{MEM_READ_FLASH_LO, MEM_READ_FLASH_HI, MEM_READ_EE};
	localparam logic [35:0] M_AD = 36'hf00ffffff, M_EA = 36'hfffffff00, M_O = 36'hf00000000;
	logic mclk = 1'b0, rst = 1'b1, hold = 1'b1, memRdy = 1'b1, memBusy = 1'b0;
	logic rdValid = 1'b0, sckPin, sdi, sdo, progEnabled, memCmdValid, rdReq;
	logic [7:0] rdData = 8'h00, lockBits, fuseLow, fuseHigh, fuseExt, e, d;
	logic [7:0] fz [4];
	logic [31:0] resp;
	spcd_memcmd_s memCmd, rdCmd;
	spcd_memcmd_s q[$];
	int fails = 0, checks_done = 0, cycles = 0;
	spcd_programmer i_spcd_programmer (.mclk(mclk), .sckPin(sckPin), .sdo(sdi), .sdi(sdo));
	spcd_decoder #(.SIG_BYTE0(SIGS[0]), .SIG_BYTE1(SIGS[1]), .SIG_BYTE2(SIGS[2]),
		.CAL_BYTE(CAL)) i_spcd_decoder (.mclk(mclk), .rst(rst), .progHoldPin(hold),
		.sckPin(sckPin), .serial_prog_data_in(sdi), .serial_prog_data_out(sdo),
		.progEnabled(progEnabled), .lockBits(lockBits), .fuseLow(fuseLow),
		.fuseHigh(fuseHigh), .fuseExt(fuseExt), .memCmdValid(memCmdValid),
		.memCmdReady(memRdy), .memCmd(memCmd), .memBusy(memBusy), .rdReq(rdReq),
		.rdCmd(rdCmd), .rdValid(rdValid), .rdData(rdData));
	always #12.5 mclk = ~mclk;
	// memory model answers on the falling edge, like all other stimulus
	always @(negedge mclk) begin
		rdValid <= rdReq;
		rdData <= rdCmd.addr[7:0] ^ 8'h5a;
	end
	always @(posedge mclk) begin
		if (memCmdValid === 1'b1 && memRdy) q.push_back(memCmd);
		cycles++;
		if (cycles == 20000) begin
			fails++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [35:0] s, input logic [35:0] x);
		checks_done++;
		if (s !== x) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic ins(input logic [7:0] a, b, c, dd);
		i_spcd_programmer.xfer({a, b, c, dd}, resp);
	endtask
	task automatic cmd(input logic [35:0] x, input logic [35:0] m);
		repeat (4) @(negedge mclk);
		chk("cmd", (q.size() > 0) ? (q.pop_front() & m) : 36'hx, x & m);
	endtask
	initial begin
		void'($urandom(86621));
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		repeat (3) @(negedge mclk);
		chk("reset fuses", {lockBits, fuseLow, fuseHigh, fuseExt}, 32'hffffffff);
		ins(OP_ENTRY_CHIP, SUB_FUSE_LO, 8'h00, 8'h12);
		chk("refused", {progEnabled, fuseLow}, 9'h0ff);
		ins(OP_ENTRY_CHIP, SUB_ENABLE, 8'h00, 8'h00);
		chk("echo", resp[15:8], SUB_ENABLE);
		chk("enabled", progEnabled, 1'b1);
		$display("test enable done");
		for (int k = 0; k < 4; k++) begin
			fz[k] = 8'($urandom()) | 8'hc0;
			ins(OP_ENTRY_CHIP, SUBS[k], 8'h00, fz[k]);
		end
		chk("fuse ports", {lockBits, fuseLow, fuseHigh, fuseExt}, {fz[0], fz[1], fz[2], fz[3]});
		for (int k = 0; k < 4; k++) begin
			ins(k[0] ? OP_READ_FUSE : OP_READ_LOCK, k[1] ? SUB_HIGH_SEL : 8'h00, 8'h00, 8'h00);
			chk("fuse read", resp[7:0], fz[k]);
			ins(OP_READ_SIG, 8'h00, 8'(k), 8'h00);
			chk("sig", resp[7:0], SIGS[k]);
		end
		ins(OP_READ_CAL, 8'h00, 8'h00, 8'h00);
		chk("cal", resp[7:0], CAL);
		$display("test fuses done");
		q.delete();
		e = 8'($urandom());
		d = 8'($urandom());
		ins(OP_LOAD_EXT, 8'h00, e, 8'h00);
		ins(OP_LOAD_LO, 8'h00, 8'h05, d);
		cmd({MEM_LOAD_FLASH_LO, 8'h00, 16'h0005, d}, M_AD);
		ins(OP_LOAD_HI, 8'h00, 8'h05, ~d);
		cmd({MEM_LOAD_FLASH_HI, 8'h00, 16'h0005, ~d}, M_AD);
		for (int k = 0; k < 2; k++) begin
			ins(OP_WRITE_PAGE, 8'h01, 8'(k * 64), 8'h00);
			cmd({MEM_WRITE_FLASH_PAGE, e, 8'h01, 8'(k * 64), 8'h00}, M_EA);
		end
		ins(OP_LOAD_EE, 8'h00, 8'h03, d);
		cmd({MEM_LOAD_EE, 8'h00, 16'h0003, d}, M_AD);
		ins(OP_WRITE_EEPG, 8'h0a, 8'hb4, 8'h00);
		cmd({MEM_WRITE_EE_PAGE, 8'h00, 16'h0ab4, 8'h00}, M_AD);
		ins(OP_WRITE_EE, 8'h0f, 8'hff, d);
		cmd({MEM_WRITE_EE_BYTE, 8'h00, 16'h0fff, d}, M_AD);
		for (int k = 0; k < 3; k++) begin
			ins(ROP[k], 8'h0a, d, 8'h00);
			chk("read", resp[7:0], d ^ 8'h5a);
			chk("rdcmd", {rdCmd.op, rdCmd.addr}, {MOP[k], 8'h0a, d});
		end
		$display("test memory done");
		memRdy = 1'b0;
		ins(OP_ENTRY_CHIP, SUB_ERASE, 8'h00, 8'h00);
		ins(OP_POLL, 8'h00, 8'h00, 8'h00);
		chk("busy", resp[0], 1'b1);
		memRdy = 1'b1;
		cmd({MEM_CHIP_ERASE, 32'h0}, M_O);
		chk("erase lock", lockBits, 8'hff);
		memBusy = 1'b1;
		ins(OP_POLL, 8'h00, 8'h00, 8'h00);
		chk("busy mem", resp[0], 1'b1);
		memBusy = 1'b0;
		for (int k = 0; k < 4 && resp[0] !== 1'b0; k++) ins(OP_POLL, 8'h00, 8'h00, 8'h00);
		chk("ready", resp[0], 1'b0);
		hold = 1'b0;
		repeat (6) @(negedge mclk);
		chk("hold drop", progEnabled, 1'b0);
		$display("test poll done");
		test_done();
	end
endmodule
`default_nettype wire

// *** bench/spcd_decoder_checker.sv ***
/* spcd_decoder_checker: port assertions on the serial decoder.
   Assumes serial clock phases of at least 4 mclk. */
`timescale 1ns/1ps
`default_nettype none
module spcd_decoder_checker
	import spcd_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic progHoldPin,
	input wire logic sckPin,
	input wire logic serial_prog_data_out,
	input wire logic progEnabled,
	input wire logic [7:0] lockBits,
	input wire logic [7:0] fuseLow,
	input wire logic memCmdValid,
	input wire logic memCmdReady,
	input wire spcd_pkg::spcd_memcmd_s memCmd,
	input wire logic rdReq,
	input wire spcd_pkg::spcd_memcmd_s rdCmd
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	property p_rdPulse; rdReq |=> !rdReq; endproperty
	a_rdPulse: assert property (p_rdPulse) else $error("read pulse too long");
	property p_rdKind;
		rdReq |-> rdCmd.op inside {MEM_READ_FLASH_LO, MEM_READ_FLASH_HI, MEM_READ_EE};
	endproperty
	a_rdKind: assert property (p_rdKind) else $error("bad read kind");
	property p_eeAddr; rdReq && rdCmd.op == MEM_READ_EE |-> rdCmd.addr[15:12] == 4'h0; endproperty
	a_eeAddr: assert property (p_eeAddr) else $error("eeprom address too wide");
	property p_holdCmd; memCmdValid && !memCmdReady |=> memCmdValid && $stable(memCmd); endproperty
	a_holdCmd: assert property (p_holdCmd) else $error("command dropped");
	property p_eePage;
		memCmdValid && memCmd.op == MEM_WRITE_EE_PAGE |-> memCmd.addr[1:0] == 2'h0;
	endproperty
	a_eePage: assert property (p_eePage) else $error("page low bits set");
	property p_eeLoad; memCmdValid && memCmd.op == MEM_LOAD_EE |-> memCmd.addr[15:2] == 14'h0; endproperty
	a_eeLoad: assert property (p_eeLoad) else $error("buffer index too wide");
	property p_holdDrop; !progHoldPin [*5] |-> !progEnabled; endproperty
	a_holdDrop: assert property (p_holdDrop) else $error("enable kept after hold");
	property p_outEdge; progHoldPin && $changed(serial_prog_data_out) |-> !$past(sckPin, 3); endproperty
	a_outEdge: assert property (p_outEdge) else $error("output moved off falling edge");
	property p_fuseLock; !progEnabled |=> $stable(fuseLow) && $stable(lockBits); endproperty
	a_fuseLock: assert property (p_fuseLock) else $error("fuse written while disabled");
	c_read: cover property (rdReq);
	c_page: cover property (memCmdValid && memCmd.op == MEM_WRITE_FLASH_PAGE);
	c_enable: cover property ($rose(progEnabled));
endmodule
bind spcd_decoder spcd_decoder_checker i_spcd_decoder_checker (.*);
`default_nettype wire

// *** bench/spcd_programmer.sv ***
/* spcd_programmer: model of the external programmer on the serial link.
   Assumes mclk at 40 MHz; one link bit is 8 mclk (200 ns). */
`timescale 1ns/1ps
`default_nettype none
module spcd_programmer (
	input wire logic mclk,
	output logic sckPin,
	output logic sdo,
	input wire logic sdi
);
	initial begin
		sckPin = 1'b0;
		sdo = 1'b0;
	end
	task automatic xfer(input logic [31:0] ins, output logic [31:0] resp);
		for (int i = 31; i >= 0; i--) begin
			sckPin = 1'b0;
			sdo = ins[i];
			repeat (4) @(negedge mclk);
			sckPin = 1'b1;
			repeat (4) @(negedge mclk);
			resp[i] = sdi;
		end
		sckPin = 1'b0;
		repeat (8) @(negedge mclk);
	endtask
endmodule
`default_nettype wire

// *** verilog/spcd_decoder.sv ***
/*
 * spcd_fifo and spcd_decoder: the four-byte serial programming instruction
 * decoder and the command FIFO toward the memory controller. Assumes the
 * serial clock, data and reset-hold pins are asynchronous to mclk, and that
 * the memory controller answers a read request within two mclk cycles.
 */
`timescale 1ns/1ps
`default_nettype none
module spcd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sValid,
	output logic sReady,
	input wire logic [WIDTH-1:0] sData,
	output logic mValid,
	input wire logic mReady,
	output logic [WIDTH-1:0] mData
);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [CW-1:0] count_ff;
	logic [CW-1:0] nxt_count;
	logic valid_ff;
	logic push;
	logic pop;
	assign push = sValid && sReady;
	assign pop = mValid && mReady;
	assign sReady = (count_ff != CW'(DEPTH));
	// valid kept in its own flop so the head flag leaves without a compare
	assign mValid = valid_ff;
	// head always sits in slot zero so the output is a flop
	assign mData = mem_ff[0];
	always_comb begin
		nxt_count = count_ff;
		if (push && !pop) begin
			nxt_count = count_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_count = count_ff - 1'b1;
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			count_ff <= '0;
			valid_ff <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			valid_ff <= (nxt_count != '0);
		end
	end
	always_ff @(posedge mclk) begin
		for (int i = 0; i < DEPTH; i++) begin
			if (pop) begin
				if (push && (CW'(i) == count_ff - 1'b1)) begin
					mem_ff[i] <= sData;
				end else if (i < DEPTH - 1) begin
					mem_ff[i] <= mem_ff[i+1];
				end
			end else if (push && (CW'(i) == count_ff)) begin
				mem_ff[i] <= sData;
			end
		end
	end
endmodule

module spcd_decoder #(
	parameter logic [7:0] SIG_BYTE0 = 8'h11, // arbitrary value
	parameter logic [7:0] SIG_BYTE1 = 8'h22, // arbitrary value
	parameter logic [7:0] SIG_BYTE2 = 8'h33, // arbitrary value
	parameter logic [7:0] CAL_BYTE = 8'h80
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic progHoldPin,
	input wire logic sckPin,
	input wire logic serial_prog_data_in,
	output logic serial_prog_data_out,
	output logic progEnabled,
	output logic [7:0] lockBits,
	output logic [7:0] fuseLow,
	output logic [7:0] fuseHigh,
	output logic [7:0] fuseExt,
	output logic memCmdValid,
	input wire logic memCmdReady,
	output spcd_pkg::spcd_memcmd_s memCmd,
	input wire logic memBusy,
	output logic rdReq,
	output spcd_pkg::spcd_memcmd_s rdCmd,
	input wire logic rdValid,
	input wire logic [7:0] rdData
);
	import spcd_pkg::*;

	logic [1:0] sckSync_ff, sdiSync_ff, holdSync_ff;
	logic sckLast_ff;
	logic sckRise, sckFall, held;
	logic [7:0] rxShift_ff, txShift_ff;
	logic [2:0] bitCnt_ff;
	logic [1:0] byteCnt_ff;
	logic [7:0] byte1_ff, byte2_ff, byte3_ff;
	logic [7:0] extAddr_ff;
	logic [7:0] rxByte;
	logic byteDone;
	logic pushValid_ff;
	spcd_memcmd_s pushCmd_ff;
	logic fifoReady, fifoValid;
	logic busy;

	always_ff @(posedge mclk) begin
		if (rst) begin
			sckSync_ff <= '0;
			sdiSync_ff <= '0;
			holdSync_ff <= '0;
			sckLast_ff <= 1'b0;
		end else begin
			sckSync_ff <= {sckSync_ff[0], sckPin};
			sdiSync_ff <= {sdiSync_ff[0], serial_prog_data_in};
			holdSync_ff <= {holdSync_ff[0], progHoldPin};
			sckLast_ff <= sckSync_ff[1];
		end
	end

	assign sckRise = sckSync_ff[1] && !sckLast_ff;
	assign sckFall = !sckSync_ff[1] && sckLast_ff;
	assign held = holdSync_ff[1];
	assign rxByte = {rxShift_ff[6:0], sdiSync_ff[1]};
	assign byteDone = held && sckRise && (bitCnt_ff == 3'(BYTE_BITS - 1));
	assign busy = memBusy || fifoValid || pushValid_ff;

	always_ff @(posedge mclk) begin
		if (rst || !held) begin
			rxShift_ff <= '0;
			bitCnt_ff <= '0;
			byteCnt_ff <= '0;
		end else if (sckRise) begin
			rxShift_ff <= rxByte;
			bitCnt_ff <= bitCnt_ff + 1'b1;
			if (bitCnt_ff == 3'(BYTE_BITS - 1)) begin
				byteCnt_ff <= byteCnt_ff + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			byte1_ff <= '0;
			byte2_ff <= '0;
			byte3_ff <= '0;
		end else if (byteDone) begin
			case (byteCnt_ff)
				2'd0: byte1_ff <= rxByte;
				2'd1: byte2_ff <= rxByte;
				2'd2: byte3_ff <= rxByte;
				default: ;
			endcase
		end
	end

	// reply byte loaded at byte end, shifted out on falling edges
	always_ff @(posedge mclk) begin
		if (rst || !held) begin
			txShift_ff <= '0;
			serial_prog_data_out <= 1'b0;
		end else if (byteDone) begin
			txShift_ff <= rxByte;
			if (byteCnt_ff == 2'd2 && progEnabled) begin
				case (byte1_ff)
					OP_POLL: txShift_ff <= {7'h00, busy};
					OP_READ_LOCK: txShift_ff <= (byte2_ff == SUB_HIGH_SEL) ? fuseHigh : lockBits;
					OP_READ_FUSE: txShift_ff <= (byte2_ff == SUB_HIGH_SEL) ? fuseExt : fuseLow;
					OP_READ_SIG: begin
						case (rxByte[1:0])
							2'd0: txShift_ff <= SIG_BYTE0;
							2'd1: txShift_ff <= SIG_BYTE1;
							2'd2: txShift_ff <= SIG_BYTE2;
							default: txShift_ff <= 8'hff;
						endcase
					end
					OP_READ_CAL: txShift_ff <= CAL_BYTE;
					default: ;
				endcase
			end
		end else if (rdValid) begin
			txShift_ff <= rdData;
		end else if (sckFall) begin
			serial_prog_data_out <= txShift_ff[7];
			txShift_ff <= {txShift_ff[6:0], 1'b0};
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || !held) begin
			progEnabled <= 1'b0;
		end else if (byteDone && byteCnt_ff == 2'd3 && byte1_ff == OP_ENTRY_CHIP
				&& byte2_ff == SUB_ENABLE) begin
			progEnabled <= 1'b1;
		end
	end

	// fuse and lock writes; reset to unprogrammed ones
	always_ff @(posedge mclk) begin
		if (rst) begin
			lockBits <= FUSE_RESET;
			fuseLow <= FUSE_RESET;
			fuseHigh <= FUSE_RESET;
			fuseExt <= FUSE_RESET;
		end else if (byteDone && byteCnt_ff == 2'd3 && progEnabled
				&& byte1_ff == OP_ENTRY_CHIP) begin
			case (byte2_ff)
				SUB_LOCK: lockBits <= rxByte;
				SUB_FUSE_LO: fuseLow <= rxByte;
				SUB_FUSE_HI: fuseHigh <= rxByte;
				SUB_FUSE_EXT: fuseExt <= rxByte;
				SUB_ERASE: lockBits <= FUSE_RESET;
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			extAddr_ff <= '0;
		end else if (byteDone && byteCnt_ff == 2'd3 && progEnabled
				&& byte1_ff == OP_LOAD_EXT) begin
			extAddr_ff <= byte3_ff;
		end
	end

	// reads issued once the third byte is in
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdReq <= 1'b0;
			rdCmd <= '0;
		end else begin
			rdReq <= 1'b0;
			if (byteDone && byteCnt_ff == 2'd2 && progEnabled) begin
				rdCmd <= '{op: MEM_NONE, ext: extAddr_ff, addr: {byte2_ff, rxByte}, data: 8'h00};
				case (byte1_ff)
					OP_READ_LO: begin
						rdReq <= 1'b1;
						rdCmd.op <= MEM_READ_FLASH_LO;
					end
					OP_READ_HI: begin
						rdReq <= 1'b1;
						rdCmd.op <= MEM_READ_FLASH_HI;
					end
					OP_READ_EE: begin
						rdReq <= 1'b1;
						rdCmd.op <= MEM_READ_EE;
						rdCmd.addr <= {4'h0, byte2_ff[3:0], rxByte};
					end
					default: ;
				endcase
			end
		end
	end

	// memory-side commands decoded at the fourth byte, held until the FIFO takes them
	always_ff @(posedge mclk) begin
		if (rst) begin
			pushValid_ff <= 1'b0;
			pushCmd_ff <= '0;
		end else if (pushValid_ff && !fifoReady) begin
			pushValid_ff <= 1'b1;
		end else if (byteDone && byteCnt_ff == 2'd3 && progEnabled) begin
			pushValid_ff <= 1'b1;
			pushCmd_ff <= '{op: MEM_NONE, ext: extAddr_ff, addr: {byte2_ff, byte3_ff},
				data: rxByte};
			case (byte1_ff)
				OP_ENTRY_CHIP: begin
					pushValid_ff <= (byte2_ff == SUB_ERASE);
					pushCmd_ff.op <= MEM_CHIP_ERASE;
				end
				OP_LOAD_LO: pushCmd_ff.op <= MEM_LOAD_FLASH_LO;
				OP_LOAD_HI: pushCmd_ff.op <= MEM_LOAD_FLASH_HI;
				OP_LOAD_EE: begin
					pushCmd_ff.op <= MEM_LOAD_EE;
					pushCmd_ff.addr <= {14'h0000, byte3_ff[1:0]};
				end
				OP_WRITE_PAGE: pushCmd_ff.op <= MEM_WRITE_FLASH_PAGE;
				OP_WRITE_EEPG: begin
					pushCmd_ff.op <= MEM_WRITE_EE_PAGE;
					pushCmd_ff.addr <= {4'h0, byte2_ff[3:0], byte3_ff[7:2], 2'b00};
				end
				OP_WRITE_EE: begin
					pushCmd_ff.op <= MEM_WRITE_EE_BYTE;
					pushCmd_ff.addr <= {4'h0, byte2_ff[3:0], byte3_ff};
				end
				default: pushValid_ff <= 1'b0;
			endcase
		end else begin
			pushValid_ff <= 1'b0;
		end
	end

	spcd_fifo #(
		.WIDTH($bits(spcd_memcmd_s)),
		.DEPTH(FIFO_DEPTH)
	) cmdFifo (
		.mclk(mclk),
		.rst(rst),
		.sValid(pushValid_ff),
		.sReady(fifoReady),
		.sData(pushCmd_ff),
		.mValid(fifoValid),
		.mReady(memCmdReady),
		.mData(memCmd)
	);
	assign memCmdValid = fifoValid;
endmodule
`default_nettype wire

// *** verilog/spcd_pkg.sv ***
/*
 * spcd_pkg: shared constants, opcodes and carrier types for the serial
 * programming command decoder. Assumes an 8-bit instruction byte stream.
 */
`default_nettype none
package spcd_pkg;
	// instruction first bytes
	localparam logic [7:0] OP_ENTRY_CHIP = 8'hac;
	localparam logic [7:0] OP_POLL = 8'hf0;
	localparam logic [7:0] OP_LOAD_EXT = 8'h4d;
	localparam logic [7:0] OP_LOAD_HI = 8'h48;
	localparam logic [7:0] OP_LOAD_LO = 8'h40;
	localparam logic [7:0] OP_LOAD_EE = 8'hc1;
	localparam logic [7:0] OP_READ_HI = 8'h28;
	localparam logic [7:0] OP_READ_LO = 8'h20;
	localparam logic [7:0] OP_READ_EE = 8'ha0;
	localparam logic [7:0] OP_READ_LOCK = 8'h58;
	localparam logic [7:0] OP_READ_SIG = 8'h30;
	localparam logic [7:0] OP_READ_FUSE = 8'h50;
	localparam logic [7:0] OP_READ_CAL = 8'h38;
	localparam logic [7:0] OP_WRITE_PAGE = 8'h4c;
	localparam logic [7:0] OP_WRITE_EE = 8'hc0;
	localparam logic [7:0] OP_WRITE_EEPG = 8'hc2;
	// second bytes under OP_ENTRY_CHIP and the read selectors
	localparam logic [7:0] SUB_ENABLE = 8'h53;
	localparam logic [7:0] SUB_ERASE = 8'h80;
	localparam logic [7:0] SUB_LOCK = 8'he0;
	localparam logic [7:0] SUB_FUSE_LO = 8'ha0;
	localparam logic [7:0] SUB_FUSE_HI = 8'ha8;
	localparam logic [7:0] SUB_FUSE_EXT = 8'ha4;
	localparam logic [7:0] SUB_HIGH_SEL = 8'h08;
	// unprogrammed value of every fuse and lock bit
	localparam logic [7:0] FUSE_RESET = 8'hff;
	localparam int FIFO_DEPTH = 4;
	localparam int BYTE_BITS = 8;

	typedef enum logic [3:0] {
		MEM_NONE, MEM_CHIP_ERASE, MEM_LOAD_FLASH_LO, MEM_LOAD_FLASH_HI, MEM_LOAD_EE,
		MEM_WRITE_FLASH_PAGE, MEM_WRITE_EE_PAGE, MEM_WRITE_EE_BYTE,
		MEM_READ_FLASH_LO, MEM_READ_FLASH_HI, MEM_READ_EE
	} spcd_memop_e;

	// one memory operation: ext is the extended address byte, addr the word/byte address
	typedef struct packed {
		spcd_memop_e op;
		logic [7:0] ext;
		logic [15:0] addr;
		logic [7:0] data;
	} spcd_memcmd_s;
endpackage
`default_nettype wire
